// File: logic/dtc_pkg.sv
// Constants for the dual timer/counter with two external interrupt inputs.
// Assumes a 32-bit classic Wishbone slave port; registers take one word each.
// What this block does
// - Timer A counts only while its run bit set, except its high byte in mode 11, which runs on B's run bit
// - Interrupt B flag set by pin, edge/level clearing
// - Interrupt A flag set by pin, edge/level clearing
// - Interrupt B type bit picks edge or level
// - Interrupt A type bit picks edge or level
// - Timer B gate bit ANDs run with pin B
// - Timer A gate bit ANDs run with pin A
// - Timer B source: internal clock or count pin
// - Timer A source: internal clock or count pin
// - Mode bits 5:4 select timer B mode
// - Mode bits 1:0 select timer A mode
// - Mode 00: 13-bit counter, 5-bit prescale low byte
// - Mode 01: full 16-bit counter
// - Mode 10: 8-bit counter reloaded from high byte
// - Mode 11: timer A split into two bytes
// - Internal increment once per twelve-clock machine cycle
package dtc_pkg;

    localparam int unsigned ADR_W    = 10;
    localparam int unsigned DAT_W    = 32;
    localparam int unsigned PRESC_W  = 5;
    localparam int unsigned MC_CLKS_DEF = 12;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h88;
    localparam logic [7:0] IDX_MODE = 8'h89;
    localparam logic [7:0] IDX_A_LO = 8'h8A;
    localparam logic [7:0] IDX_B_LO = 8'h8B;
    localparam logic [7:0] IDX_A_HI = 8'h8C;
    localparam logic [7:0] IDX_B_HI = 8'h8D;
    localparam logic [7:0] IDX_STAT = 8'h8E;
    localparam logic [7:0] IDX_MASK = 8'h8F;

    // Mode register fields
    localparam int unsigned MD_B_GATE = 7;
    localparam int unsigned MD_B_CT   = 6;
    localparam int unsigned MD_B_HI   = 5;
    localparam int unsigned MD_B_LO   = 4;
    localparam int unsigned MD_A_GATE = 3;
    localparam int unsigned MD_A_CT   = 2;
    localparam int unsigned MD_A_HI   = 1;
    localparam int unsigned MD_A_LO   = 0;

    // Control register fields
    localparam int unsigned CT_B_OVF  = 7;
    localparam int unsigned CT_B_RUN  = 6;
    localparam int unsigned CT_A_OVF  = 5;
    localparam int unsigned CT_A_RUN  = 4;
    localparam int unsigned CT_B_FLAG = 3;
    localparam int unsigned CT_B_TYPE = 2;
    localparam int unsigned CT_A_FLAG = 1;
    localparam int unsigned CT_A_TYPE = 0;

    // Status and mask bits
    localparam int unsigned ST_A_OVF = 0;
    localparam int unsigned ST_B_OVF = 1;
    localparam int unsigned ST_IRQ_A = 2;
    localparam int unsigned ST_IRQ_B = 3;
    localparam int unsigned ST_W     = 4;

    // Synchronised pin slots
    localparam int unsigned PIN_IRQ_A = 0;
    localparam int unsigned PIN_IRQ_B = 1;
    localparam int unsigned PIN_CNT_A = 2;
    localparam int unsigned PIN_CNT_B = 3;
    localparam int unsigned NUM_PINS  = 4;

    localparam logic [7:0]    REG_RST  = 8'h00;
    localparam logic [ST_W-1:0] ST_RST = 4'h0;

    typedef enum logic [1:0] {
        DTC_M13   = 2'b00,
        DTC_M16   = 2'b01,
        DTC_M8R   = 2'b10,
        DTC_SPLIT = 2'b11
    } dtc_mode_type;

endpackage

// File: logic/dtc_sync.sv
// Three-stage pin synchroniser, one lane per pin.
// Assumes idle-high pins; stages reset high so no false edge at release.
`timescale 1ns/1ps
`default_nettype none
module dtc_sync #(
    parameter int unsigned N = 4
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic [N-1:0] pin_in,
    output logic      [N-1:0] s2_out,
    output logic      [N-1:0] s3_out
);

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
    } dtc_sync_state_type;

    dtc_sync_state_type r_reg;
    dtc_sync_state_type r_next;

    if (N < 1) begin : g_bad_n
        $error("dtc_sync needs at least one lane");
    end

    // Shift chain; stage one feeds stage two only
    always_comb begin
        r_next    = r_reg;
        r_next.s1 = pin_in;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r_reg <= '1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign s2_out = r_reg.s2;
    assign s3_out = r_reg.s3;

endmodule
`default_nettype wire

// File: logic/dtc_top.sv
// Dual 16-bit timer/counter with two external interrupt inputs.
// Assumes a classic Wishbone master on clk_in; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module dtc_top #(
    parameter int unsigned MC_CLKS = dtc_pkg::MC_CLKS_DEF
) (
    input  wire logic                      clk_in,
    input  wire logic                      rst_in,
    input  wire logic                      wb_cyc_in,
    input  wire logic                      wb_stb_in,
    input  wire logic                      wb_we_in,
    input  wire logic [dtc_pkg::ADR_W-1:0] wb_adr_in,
    input  wire logic [3:0]                wb_sel_in,
    input  wire logic [dtc_pkg::DAT_W-1:0] wb_dat_in,
    output logic                           wb_ack_out,
    output logic      [dtc_pkg::DAT_W-1:0] wb_dat_out,
    input  wire logic                      ext_irq_a_pin_in,
    input  wire logic                      ext_irq_b_pin_in,
    input  wire logic                      count_a_pin_in,
    input  wire logic                      count_b_pin_in,
    input  wire logic                      ext_irq_a_vector_in,
    input  wire logic                      ext_irq_b_vector_in,
    output logic                           ext_irq_a_flag_out,
    output logic                           ext_irq_b_flag_out,
    output logic                           timer_a_ovf_out,
    output logic                           timer_b_ovf_out,
    output logic                           irq_out
);
    import dtc_pkg::*;

    localparam int unsigned MC_W = $clog2(MC_CLKS);
    localparam logic [MC_W-1:0] MC_LAST = MC_W'(MC_CLKS - 1);

    // A one-clock cycle leaves the divider no bits; above 256 it only wastes area
    if (MC_CLKS < 2 || MC_CLKS > 256) begin : g_bad_mc
        $error("MC_CLKS out of range");
    end

    typedef struct packed {
        logic [7:0]          mode;
        logic [7:0]          ctrl;
        logic [7:0]          a_lo;
        logic [7:0]          a_hi;
        logic [7:0]          b_lo;
        logic [7:0]          b_hi;
        logic [ST_W-1:0]     stat;
        logic [ST_W-1:0]     mask;
        logic [MC_W-1:0]     mc_cnt;
        logic [NUM_PINS-1:0] lvl;
        logic                ack;
        logic [DAT_W-1:0]    dat;
        logic                irq;
    } dtc_state_type;

    dtc_state_type r_reg;
    dtc_state_type r_next;

    logic [NUM_PINS-1:0] pin_s2;
    logic [NUM_PINS-1:0] pin_s3;
    logic [NUM_PINS-1:0] fall;
    logic                mc;
    logic                acc;
    logic                wr;
    logic                rd;
    logic [7:0]          idx;
    dtc_mode_type        mode_a;
    dtc_mode_type        mode_b;
    logic                split;
    logic                inc_a;
    logic                inc_b;
    logic                inc_ah;
    logic [16:0]         step_a;
    logic [16:0]         step_b;
    logic [8:0]          sum_ah;
    logic                ovf_a;
    logic                ovf_b;
    logic                set_a;
    logic                set_b;

    // Step one counter by one increment in the given mode
    function automatic logic [16:0] dtc_step(input dtc_mode_type m,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi,
                                             input logic inc);
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0]  c8;
        logic [16:0] res;
        c13 = {1'b0, hi, lo[PRESC_W-1:0]} + 14'h0001;
        c16 = {1'b0, hi, lo} + 17'h00001;
        c8  = {1'b0, lo} + 9'h001;
        res = {1'b0, hi, lo};
        if (inc) begin
            unique case (m)
                DTC_M13:   res = {c13[13], c13[12:PRESC_W], lo[7:PRESC_W],
                                  c13[PRESC_W-1:0]};
                DTC_M16:   res = c16;
                DTC_M8R:   res = {c8[8], hi, c8[8] ? hi : c8[7:0]};
                DTC_SPLIT: res = {c8[8], hi, c8[7:0]};
            endcase
        end
        return res;
    endfunction

    // Pins are asynchronous, so every one goes through three stages
    dtc_sync #(
        .N (NUM_PINS)
    ) u_sync (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .pin_in ({count_b_pin_in, count_a_pin_in, ext_irq_b_pin_in, ext_irq_a_pin_in}),
        .s2_out (pin_s2),
        .s3_out (pin_s3)
    );

    // A falling edge counts once stages two and three agree low
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_fall
            assign fall[gi] = r_reg.lvl[gi] & (pin_s2[gi] == pin_s3[gi]) & ~pin_s2[gi];
        end
    endgenerate

    // Bus decode; one wait state, so ack never sits on a new request
    assign acc = wb_cyc_in & wb_stb_in & ~r_reg.ack;
    assign wr  = acc & wb_we_in & wb_sel_in[0];
    assign rd  = acc & ~wb_we_in;
    assign idx = wb_adr_in[9:2];

    // Mode fields per timer
    assign mode_a = dtc_mode_type'({r_reg.mode[MD_A_HI], r_reg.mode[MD_A_LO]});
    assign mode_b = dtc_mode_type'({r_reg.mode[MD_B_HI], r_reg.mode[MD_B_LO]});
    assign split  = (mode_a == DTC_SPLIT);

    // Machine-cycle tick from the clock divider
    assign mc = (r_reg.mc_cnt == MC_LAST);

    // Run, gate and source select per timer
    assign inc_a = r_reg.ctrl[CT_A_RUN]
                 & (~r_reg.mode[MD_A_GATE] | r_reg.lvl[PIN_IRQ_A])
                 & (r_reg.mode[MD_A_CT] ? fall[PIN_CNT_A] : mc);
    assign inc_b = r_reg.ctrl[CT_B_RUN]
                 & (~r_reg.mode[MD_B_GATE] | r_reg.lvl[PIN_IRQ_B])
                 & (r_reg.mode[MD_B_CT] ? fall[PIN_CNT_B] : mc)
                 & (mode_b != DTC_SPLIT);

    // Split high byte of A is a plain timer under B's run bit
    assign inc_ah = split & r_reg.ctrl[CT_B_RUN] & mc;
    assign sum_ah = {1'b0, r_reg.a_hi} + 9'h001;

    assign step_a = dtc_step(mode_a, r_reg.a_lo, r_reg.a_hi, inc_a);
    assign step_b = dtc_step(mode_b, r_reg.b_lo, r_reg.b_hi, inc_b);

    // In split mode B's flag belongs to A's high byte
    assign ovf_a = step_a[16];
    assign ovf_b = split ? (inc_ah & sum_ah[8]) : step_b[16];

    // Detect conditions: edge when type set, low level otherwise
    assign set_a = r_reg.ctrl[CT_A_TYPE] ? fall[PIN_IRQ_A] : ~r_reg.lvl[PIN_IRQ_A];
    assign set_b = r_reg.ctrl[CT_B_TYPE] ? fall[PIN_IRQ_B] : ~r_reg.lvl[PIN_IRQ_B];

    // Next state of everything
    always_comb begin
        r_next = r_reg;

        // Filtered pin levels follow once two stages agree
        for (int i = 0; i < NUM_PINS; i++) begin
            if (pin_s2[i] == pin_s3[i]) begin
                r_next.lvl[i] = pin_s2[i];
            end
        end

        r_next.mc_cnt = mc ? '0 : MC_W'(r_reg.mc_cnt + 1'b1);

        // Counters; a bus write to a byte overrides that byte's increment
        r_next.a_lo = step_a[7:0];
        r_next.a_hi = split ? (inc_ah ? sum_ah[7:0] : r_reg.a_hi) : step_a[15:8];
        r_next.b_lo = step_b[7:0];
        r_next.b_hi = step_b[15:8];

        if (wr) begin
            unique case (idx)
                IDX_CTRL: r_next.ctrl = wb_dat_in[7:0];
                IDX_MODE: r_next.mode = wb_dat_in[7:0];
                IDX_A_LO: r_next.a_lo = wb_dat_in[7:0];
                IDX_A_HI: r_next.a_hi = wb_dat_in[7:0];
                IDX_B_LO: r_next.b_lo = wb_dat_in[7:0];
                IDX_B_HI: r_next.b_hi = wb_dat_in[7:0];
                IDX_MASK: r_next.mask = wb_dat_in[ST_W-1:0];
                default:  r_next.ctrl = r_reg.ctrl;
            endcase
        end

        // External flags: vectoring clears edge flags, a new edge wins
        if (r_reg.ctrl[CT_A_TYPE]) begin
            if (ext_irq_a_vector_in) r_next.ctrl[CT_A_FLAG] = 1'b0;
            if (set_a) r_next.ctrl[CT_A_FLAG] = 1'b1;
        end else begin
            r_next.ctrl[CT_A_FLAG] = ~r_reg.lvl[PIN_IRQ_A];
        end
        if (r_reg.ctrl[CT_B_TYPE]) begin
            if (ext_irq_b_vector_in) r_next.ctrl[CT_B_FLAG] = 1'b0;
            if (set_b) r_next.ctrl[CT_B_FLAG] = 1'b1;
        end else begin
            r_next.ctrl[CT_B_FLAG] = ~r_reg.lvl[PIN_IRQ_B];
        end

        // Overflow flags; hardware set beats a software clear
        if (ovf_a) r_next.ctrl[CT_A_OVF] = 1'b1;
        if (ovf_b) r_next.ctrl[CT_B_OVF] = 1'b1;

        // Sticky status, cleared by its own read; new events still land
        if (rd && idx == IDX_STAT) r_next.stat = ST_RST;
        r_next.stat[ST_A_OVF] = r_next.stat[ST_A_OVF] | ovf_a;
        r_next.stat[ST_B_OVF] = r_next.stat[ST_B_OVF] | ovf_b;
        r_next.stat[ST_IRQ_A] = r_next.stat[ST_IRQ_A] | set_a;
        r_next.stat[ST_IRQ_B] = r_next.stat[ST_IRQ_B] | set_b;

        // Bus answer; unmapped reads return zero but still ack
        r_next.ack = acc;
        r_next.dat = '0;
        if (rd) begin
            unique case (idx)
                IDX_CTRL: r_next.dat = {24'h000000, r_reg.ctrl};
                IDX_MODE: r_next.dat = {24'h000000, r_reg.mode};
                IDX_A_LO: r_next.dat = {24'h000000, r_reg.a_lo};
                IDX_A_HI: r_next.dat = {24'h000000, r_reg.a_hi};
                IDX_B_LO: r_next.dat = {24'h000000, r_reg.b_lo};
                IDX_B_HI: r_next.dat = {24'h000000, r_reg.b_hi};
                IDX_STAT: r_next.dat = {28'h0000000, r_reg.stat};
                IDX_MASK: r_next.dat = {28'h0000000, r_reg.mask};
                default:  r_next.dat = '0;
            endcase
        end

        r_next.irq = |(r_next.stat & r_next.mask);
    end

    // Single state register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r_reg        <= '0;
            r_reg.lvl    <= '1;
            r_reg.mode   <= REG_RST;
            r_reg.ctrl   <= REG_RST;
            r_reg.stat   <= ST_RST;
            r_reg.mask   <= ST_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state register
    assign wb_ack_out         = r_reg.ack;
    assign wb_dat_out         = r_reg.dat;
    assign irq_out            = r_reg.irq;
    assign ext_irq_a_flag_out = r_reg.ctrl[CT_A_FLAG];
    assign ext_irq_b_flag_out = r_reg.ctrl[CT_B_FLAG];
    assign timer_a_ovf_out    = r_reg.ctrl[CT_A_OVF];
    assign timer_b_ovf_out    = r_reg.ctrl[CT_B_OVF];

    // Checks on the timer and flag logic
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_run_stops: assert property (
        !r_reg.ctrl[CT_A_RUN] && !wr |=> $stable(r_reg.a_lo))
        else $error("timer A low byte moved while stopped");

    a_irqb_level: assert property (
        !r_reg.ctrl[CT_B_TYPE] |=> ext_irq_b_flag_out == !$past(r_reg.lvl[PIN_IRQ_B]))
        else $error("level flag B does not follow inverted pin");

    a_irqa_edge: assert property (
        r_reg.ctrl[CT_A_TYPE] && fall[PIN_IRQ_A] && !wr |=> ext_irq_a_flag_out)
        else $error("edge on pin A did not set flag");

    a_typeb_noedge: assert property (
        r_reg.ctrl[CT_B_TYPE] && !fall[PIN_IRQ_B] && !ext_irq_b_flag_out && !wr
        |=> !ext_irq_b_flag_out)
        else $error("edge-mode flag B set without edge");

    a_typea_noedge: assert property (
        r_reg.ctrl[CT_A_TYPE] && !fall[PIN_IRQ_A] && !ext_irq_a_flag_out && !wr
        |=> !ext_irq_a_flag_out)
        else $error("edge-mode flag A set without edge");

    a_gate_b: assert property (
        r_reg.mode[MD_B_GATE] && !r_reg.lvl[PIN_IRQ_B] && !wr |=> $stable(r_reg.b_lo))
        else $error("timer B counted with gate pin low");

    a_gate_a: assert property (
        r_reg.mode[MD_A_GATE] && !r_reg.lvl[PIN_IRQ_A] && !wr |=> $stable(r_reg.a_lo))
        else $error("timer A counted with gate pin low");

    a_rate_a: assert property (
        r_reg.ctrl[CT_A_RUN] && !r_reg.mode[MD_A_GATE] && !r_reg.mode[MD_A_CT]
        && mode_a == DTC_M16 && mc && r_reg.a_lo != 8'hFF && !wr
        |=> r_reg.a_lo == $past(r_reg.a_lo) + 8'h01 ##1 $stable(r_reg.a_lo))
        else $error("timer A did not step once per machine cycle");

    a_pin_b: assert property (
        r_reg.mode[MD_B_CT] && !fall[PIN_CNT_B] && !wr |=> $stable(r_reg.b_lo))
        else $error("timer B counted without a count pin edge");

    a_m13_carry: assert property (
        mode_a == DTC_M13 && inc_a && r_reg.a_lo[4:0] == 5'h1F && r_reg.a_hi != 8'hFF && !wr
        |=> r_reg.a_lo[4:0] == 5'h00 && r_reg.a_hi == $past(r_reg.a_hi) + 8'h01)
        else $error("prescale carry did not reach high byte");

    a_reload: assert property (
        mode_a == DTC_M8R && inc_a && r_reg.a_lo == 8'hFF && !wr
        |=> r_reg.a_lo == $past(r_reg.a_hi) && timer_a_ovf_out)
        else $error("auto-reload or its flag failed");

    a_b_hold: assert property (
        mode_b == DTC_SPLIT && !wr |=> $stable({r_reg.b_hi, r_reg.b_lo}))
        else $error("timer B moved in mode 11");

    a_split_hi: assert property (
        split && inc_ah && r_reg.a_hi == 8'hFF && !wr |=> r_reg.a_hi == 8'h00 && timer_b_ovf_out)
        else $error("split high byte overflow lost");

    // Full-width wrap, overflow reporting and vector clearing
    a_m16_wrap: assert property (
        mode_a == DTC_M16 && inc_a && {r_reg.a_hi, r_reg.a_lo} == 16'hFFFF && !wr
        |=> {r_reg.a_hi, r_reg.a_lo} == 16'h0000 && timer_a_ovf_out)
        else $error("16-bit wrap of timer A failed");

    a_ovf_sets: assert property (
        ovf_a |=> timer_a_ovf_out && r_reg.stat[ST_A_OVF])
        else $error("timer A overflow not flagged");

    a_vec_clear_a: assert property (
        r_reg.ctrl[CT_A_TYPE] && ext_irq_a_vector_in && !set_a && !wr |=> !ext_irq_a_flag_out)
        else $error("vectoring did not clear edge flag A");

    a_vec_clear_b: assert property (
        r_reg.ctrl[CT_B_TYPE] && ext_irq_b_vector_in && !set_b && !wr |=> !ext_irq_b_flag_out)
        else $error("vectoring did not clear edge flag B");

    c_reload: cover property (mode_a == DTC_M8R && ovf_a);
    c_edge_b: cover property (r_reg.ctrl[CT_B_TYPE] && fall[PIN_IRQ_B]);
    c_split: cover property (split && ovf_b);
    c_irq: cover property (irq_out && rd && idx == IDX_STAT);
    c_vec: cover property (r_reg.ctrl[CT_A_TYPE] && ext_irq_a_vector_in && ext_irq_a_flag_out);

endmodule
`default_nettype wire

// File: testbench/dtc_pins.sv
// Far-side model: the two interrupt request pins and the two count pins.
// Assumes the bench asks for levels; every pin rests high as on a pull-up.
`timescale 1ns/1ps
`default_nettype none
module dtc_pins (
    input  wire logic       clk_in,
    input  wire logic [3:0] lvl_in,
    output logic      [3:0] pin_out
);
    logic [3:0] pin_reg = 4'hF;
    // Levels move only on an edge, so every low or high lasts whole cycles
    always @(posedge clk_in) begin
        pin_reg <= lvl_in;
    end
    assign pin_out = pin_reg;
endmodule
`default_nettype wire

// File: testbench/dual_timer_counter_ext_irq_bench.sv
// Bench for the dual timer/counter: register tests over classic Wishbone.
// Assumes dtc_top and the pin model; machine cycle shortened to 2 clocks.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_ext_irq_bench;
    import dtc_pkg::*;
    localparam int MC = 2;
    logic        clk_in      = 1'h0;
    logic        rst_in      = 1'h1;
    logic        cyc         = 1'h0;
    logic        we          = 1'h0;
    logic [9:0]  adr         = 10'h000;
    logic [31:0] wdat        = 32'h0;
    logic [3:0]  lvl         = 4'hF;
    logic [3:0]  sel         = 4'h0;
    logic [1:0]  vec         = 2'h0;
    logic [31:0] dat;
    logic [31:0] rd;
    logic [31:0] v;
    logic        ack;
    logic [3:0]  pins;
    logic [4:0]  evt;
    int          err_total   = 0;
    int          comparisons = 0;
    int          n;
    logic [7:0]  md[3]       = '{8'h01, 8'h00, 8'h02};
    logic [7:0]  hi0[3]      = '{8'hFF, 8'hFF, 8'h5A};
    logic [7:0]  hie[3]      = '{8'h00, 8'h00, 8'h5A};
    logic [7:0]  loe[3]      = '{8'h00, 8'hE0, 8'h50};
    logic [7:0]  ix[4]       = '{IDX_CTRL, IDX_MODE, IDX_STAT, 8'h80};

    always #50 clk_in = ~clk_in;

    dtc_pins dtc_pins_inst (.clk_in(clk_in), .lvl_in(lvl), .pin_out(pins));
    dtc_top #(.MC_CLKS(MC)) dtc_top_inst (
        .clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_ack_out(ack), .wb_dat_out(dat), .ext_irq_a_pin_in(pins[0]),
        .ext_irq_b_pin_in(pins[1]), .count_a_pin_in(pins[2]), .count_b_pin_in(pins[3]),
        .ext_irq_a_vector_in(vec[0]), .ext_irq_b_vector_in(vec[1]),
        .ext_irq_a_flag_out(evt[0]), .ext_irq_b_flag_out(evt[1]),
        .timer_a_ovf_out(evt[2]), .timer_b_ovf_out(evt[3]), .irq_out(evt[4]));

    // Verdict and end of run, shared by the main flow and every timeout
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    // One classic cycle; read data is taken only at the ack edge
    task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
        int k;
        k = 0;
        cyc  <= 1'h1;
        we   <= w;
        adr  <= {i, 2'h0};
        wdat <= {24'h0, d};
        sel  <= 4'hF;
        do begin
            @(posedge clk_in);
            k++;
        end while (ack !== 1'h1 && k < 20);
        rd = dat;
        cyc <= 1'h0;
        sel <= 4'h0;
        if (k >= 20) begin
            err_total++;
            $display("BAD wb_ack exp 1 got %b", ack);
            tally_and_finish();
        end
        @(posedge clk_in);
    endtask

    // Bounded wait on one output; the number of edges waited is left in n
    task automatic wait_bit(input int b, input logic s);
        n = 0;
        while (evt[b] !== s) begin
            @(posedge clk_in);
            n++;
            if (n > 300) begin
                err_total++;
                $display("BAD wait_bit %0d exp %b got %b", b, s, evt[b]);
                tally_and_finish();
            end
        end
    endtask

    // Count pin pulse, 4 cycles low and 4 high, above the 2-cycle minimum
    task automatic pulse(input int b);
        lvl[b] <= 1'h0;
        repeat (4) @(posedge clk_in);
        lvl[b] <= 1'h1;
        repeat (4) @(posedge clk_in);
    endtask

    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'h0;
        repeat (4) @(posedge clk_in);
        // Reset contents, and an unmapped index that reads zero
        foreach (ix[i]) begin
            wb(1'h0, ix[i], 8'h00);
            chk("reset", 32'h0, rd);
        end
        $display("test reset done");
        wb(1'h1, IDX_MASK, 8'h01);
        // Timer A in modes 01, 00 and 10, sixteen ticks to overflow each
        for (int i = 0; i < 3; i++) begin
            wb(1'h1, IDX_MODE, md[i]);
            wb(1'h1, IDX_A_LO, 8'hF0);
            wb(1'h1, IDX_A_HI, hi0[i]);
            wb(1'h1, IDX_CTRL, 8'h10);
            wait_bit(4, 1'h1);
            chk("ticks", 32'h1, 32'(n > 25 && n < 36));
            chk("a_ovf", 32'h1, 32'(evt[2]));
            wb(1'h1, IDX_CTRL, 8'h00);
            wb(1'h0, IDX_A_HI, 8'h00);
            chk("a_hi", 32'(hie[i]), rd);
            wb(1'h0, IDX_A_LO, 8'h00);
            v = rd;
            chk("a_lo", 32'(loe[i]), rd & 32'hF0);
            wb(1'h0, IDX_A_LO, 8'h00);
            chk("a_stop", v, rd);
            wb(1'h0, IDX_STAT, 8'h00);
            chk("stat_ovf", 32'h1, rd);
            chk("irq_off", 32'h0, 32'(evt[4]));
        end
        $display("test modes done");
        // Split mode: A high byte runs on B's run bit, timer B holds
        wb(1'h1, IDX_MODE, 8'h33);
        wb(1'h1, IDX_A_LO, 8'h22);
        wb(1'h1, IDX_A_HI, 8'hFE);
        wb(1'h1, IDX_B_LO, 8'h77);
        wb(1'h1, IDX_CTRL, 8'h40);
        wait_bit(3, 1'h1);
        chk("split_time", 32'h1, 32'(n < 10));
        wb(1'h0, IDX_B_LO, 8'h00);
        chk("b_held", 32'h77, rd);
        wb(1'h0, IDX_A_LO, 8'h00);
        chk("a_lo_idle", 32'h22, rd);
        wb(1'h1, IDX_CTRL, 8'h00);
        $display("test split done");
        // Falling edges on each count pin, then none while the gate is low
        for (int c = 0; c < 2; c++) begin
            wb(1'h1, IDX_MODE, c ? 8'hD0 : 8'h0D);
            wb(1'h1, IDX_A_LO + 8'(c), 8'h00);
            wb(1'h1, IDX_CTRL, 8'h10 << (2 * c));
            repeat (3) pulse(2 + c);
            lvl[c] <= 1'h0;
            repeat (5) @(posedge clk_in);
            repeat (2) pulse(2 + c);
            lvl[c] <= 1'h1;
            wb(1'h0, IDX_A_LO + 8'(c), 8'h00);
            chk("count", 32'h3, rd);
            wb(1'h1, IDX_CTRL, 8'h00);
        end
        $display("test count done");
        wb(1'h1, IDX_MASK, 8'h0C);
        // Edge detection with vector clear, then level detection, per pin
        for (int c = 0; c < 2; c++) begin
            // Low pins in the count test or the previous pin's level phase left status set; clear it first
            wb(1'h0, IDX_STAT, 8'h00);
            wb(1'h1, IDX_CTRL, 8'h01 << (2 * c));
            lvl[c] <= 1'h0;
            wait_bit(4, 1'h1);
            chk("flag_edge", 32'h1, 32'(evt[c]));
            lvl[c] <= 1'h1;
            repeat (8) @(posedge clk_in);
            chk("flag_kept", 32'h1, 32'(evt[c]));
            vec[c] <= 1'h1;
            @(posedge clk_in);
            vec[c] <= 1'h0;
            repeat (2) @(posedge clk_in);
            chk("flag_vec", 32'h0, 32'(evt[c]));
            wb(1'h0, IDX_STAT, 8'h00);
            chk("stat_irq", 32'h4 << c, rd);
            wb(1'h1, IDX_CTRL, 8'h00);
            lvl[c] <= 1'h0;
            wait_bit(c, 1'h1);
            lvl[c] <= 1'h1;
            wait_bit(c, 1'h0);
            chk("level_follow", 32'h1, 32'(n < 8));
        end
        $display("test irq done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
